/* common/acl_pkg.sv */
// Shared constants and types for the ASCII command line parser.
`default_nettype none
package acl_pkg;
  // Characters that steer line framing and tokenising.
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_QUOTE = 8'h22;
  // Characters used to build replies.
  localparam logic [7:0] CH_ERR = 8'h45;
  localparam logic [7:0] CH_WARN = 8'h57;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_PROMPT = 8'h3E;
  // Network port on which command lines are served.
  localparam logic [15:0] TCP_CMD_PORT = 16'h0017;
  // Outcome codes reported by the command executor.
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_WARN = 2'h1;
  localparam logic [1:0] ST_ERR = 2'h2;
  // Error numbers raised by the parser itself, three BCD digits.
  localparam logic [11:0] ERR_OVERFLOW = 12'h901;
  localparam logic [11:0] ERR_QUOTE = 12'h902;
  // Last digit position of a coded message.
  localparam logic [1:0] MSG_LAST = 2'h3;
  // Source port numbers.
  localparam logic PORT_SER = 1'b0;
  localparam logic PORT_TCP = 1'b1;
  // Main sequencer states.
  typedef enum logic [3:0] {
    S_IDLE, S_SCAN, S_WAIT, S_NAME, S_VALS, S_MSGSP, S_MSG, S_CR, S_LF, S_PROMPT
  } acl_state_e;
endpackage
`default_nettype wire

/* design/acl_parser.sv */
// Line-oriented ASCII command parser serving a serial and a TCP byte stream.
// Notes on behaviour
// - Line is name, spaced parameters, ends with LF.
// - CR just before LF is dropped silently.
// - Quoted text with spaces is one parameter.
// - No parameters means query current value.
// - Query reply is name plus resendable values.
// - Every command ends with line break, prompt.
// - Failure prints E and three digit code.
// - Warning prints W code, command still runs.
// - Serial and TCP port 23 share syntax.
`default_nettype none
module acl_parser #(
  parameter int DEPTH = 64
) (
  // Clock and reset.
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  // Serial receive stream.
  input wire logic I_SER_VALID,
  input wire logic [7:0] I_SER_DATA,
  output logic O_SER_READY,
  // TCP receive stream.
  input wire logic I_TCP_VALID,
  input wire logic [7:0] I_TCP_DATA,
  output logic O_TCP_READY,
  output logic [15:0] O_TCP_PORT_NUM,
  // Token stream to the command executor.
  output logic O_TOK_VALID,
  output logic [7:0] O_TOK_DATA,
  output logic O_TOK_FIRST,
  output logic O_TOK_NAME,
  output logic O_CMD_END,
  output logic O_CMD_QUERY,
  output logic O_CMD_PORT,
  // Executor outcome.
  input wire logic I_EXEC_DONE,
  input wire logic [1:0] I_EXEC_STATUS,
  input wire logic [11:0] I_EXEC_CODE,
  // Query value text from the executor.
  input wire logic I_VAL_VALID,
  input wire logic [7:0] I_VAL_DATA,
  input wire logic I_VAL_LAST,
  output logic O_VAL_READY,
  // Reply stream.
  output logic O_TX_VALID,
  output logic [7:0] O_TX_DATA,
  output logic O_TX_PORT,
  input wire logic I_TX_READY
);
  localparam int AW = $clog2(DEPTH);

  // Per-port ingress wires and buffer views.
  logic in_valid [2];
  logic [7:0] in_data [2];
  logic line_rdy [2];
  logic line_ovf [2];
  logic [AW:0] line_len [2];
  logic [7:0] rd_byte [2];
  logic release_p [2];
  logic [AW:0] idx_q, idx_d; // Read index into the selected buffer.

  assign in_valid[0] = I_SER_VALID;
  assign in_data[0] = I_SER_DATA;
  assign in_valid[1] = I_TCP_VALID;
  assign in_data[1] = I_TCP_DATA;
  // A port stalls while its finished line waits to be served.
  assign O_SER_READY = !line_rdy[0];
  assign O_TCP_READY = !line_rdy[1];
  assign O_TCP_PORT_NUM = acl_pkg::TCP_CMD_PORT;

  // One line buffer per port; both feed the same parser, so syntax is shared.
  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [7:0] mem [DEPTH]; // Raw line text, no reset needed.
    logic [AW:0] len_q, len_d;
    logic rdy_q, rdy_d;
    logic ovf_q, ovf_d;
    logic we;
    logic [7:0] last_byte;

    assign last_byte = mem[AW'(len_q - 1'b1)];

    // Collect bytes until LF; a line only becomes visible once complete.
    always_comb begin
      len_d = len_q;
      rdy_d = rdy_q;
      ovf_d = ovf_q;
      we = 1'b0;
      if (in_valid[p] && !rdy_q) begin
        if (in_data[p] == acl_pkg::CH_LF) begin
          rdy_d = 1'b1;
          // A CR right before LF is taken off, so CR LF acts like LF.
          if (len_q != '0 && !ovf_q && last_byte == acl_pkg::CH_CR) begin
            len_d = len_q - 1'b1;
          end
        end else if (len_q == (AW+1)'(DEPTH)) begin
          // Too long: the rest is dropped and the line is answered with an error.
          ovf_d = 1'b1;
        end else begin
          we = 1'b1;
          len_d = len_q + 1'b1;
        end
      end
      if (release_p[p]) begin
        len_d = '0;
        rdy_d = 1'b0;
        ovf_d = 1'b0;
      end
    end

    // Register the buffer state and store accepted bytes.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
        len_q <= '0;
        rdy_q <= 1'b0;
        ovf_q <= 1'b0;
      end else begin
        len_q <= len_d;
        rdy_q <= rdy_d;
        ovf_q <= ovf_d;
      end
    end

    always_ff @(posedge I_CLK) begin
      if (we) begin
        mem[len_q[AW-1:0]] <= in_data[p];
      end
    end

    assign line_rdy[p] = rdy_q;
    assign line_ovf[p] = ovf_q;
    assign line_len[p] = len_q;
    assign rd_byte[p] = mem[idx_q[AW-1:0]];
  end

  // Sequencer state.
  acl_pkg::acl_state_e state_q, state_d;
  logic sel_q, sel_d; // Port being served.
  logic rr_q, rr_d; // Port that wins a tie next time.
  logic inq_q, inq_d; // Inside quotation marks.
  logic intok_q, intok_d; // Inside a token.
  logic fresh_q, fresh_d; // Token opened by a quote, no byte yet.
  logic named_q, named_d; // Command name complete.
  logic param_q, param_d; // At least one parameter seen.
  logic [AW:0] nm_beg_q, nm_beg_d;
  logic [AW:0] nm_end_q, nm_end_d;
  logic [1:0] status_q, status_d;
  logic [11:0] code_q, code_d;
  logic [1:0] msg_q, msg_d;
  logic query_q, query_d;
  logic tok_valid_q, tok_valid_d;
  logic [7:0] tok_data_q, tok_data_d;
  logic tok_first_q, tok_first_d;
  logic tok_name_q, tok_name_d;
  logic cmd_end_q, cmd_end_d;
  logic tx_valid_q, tx_valid_d;
  logic [7:0] tx_data_q, tx_data_d;
  logic tx_free;
  logic [7:0] cur;
  logic [3:0] digit;

  assign tx_free = !tx_valid_q || I_TX_READY;
  assign cur = rd_byte[sel_q];
  assign O_VAL_READY = (state_q == acl_pkg::S_VALS) && tx_free;
  assign release_p[0] = (state_q == acl_pkg::S_PROMPT) && tx_free && (sel_q == acl_pkg::PORT_SER);
  assign release_p[1] = (state_q == acl_pkg::S_PROMPT) && tx_free && (sel_q == acl_pkg::PORT_TCP);

  // Next-state logic: pick a line, tokenise it, wait for the outcome, then reply.
  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    rr_d = rr_q;
    idx_d = idx_q;
    inq_d = inq_q;
    intok_d = intok_q;
    fresh_d = fresh_q;
    named_d = named_q;
    param_d = param_q;
    nm_beg_d = nm_beg_q;
    nm_end_d = nm_end_q;
    status_d = status_q;
    code_d = code_q;
    msg_d = msg_q;
    query_d = query_q;
    tok_valid_d = 1'b0;
    tok_data_d = tok_data_q;
    tok_first_d = tok_first_q;
    tok_name_d = tok_name_q;
    cmd_end_d = 1'b0;
    tx_valid_d = tx_valid_q && !I_TX_READY;
    tx_data_d = tx_data_q;
    digit = code_q[11:8];
    case (msg_q)
      2'h2: digit = code_q[7:4];
      2'h3: digit = code_q[3:0];
      default: digit = code_q[11:8];
    endcase
    case (state_q)
      acl_pkg::S_IDLE: begin
        // Alternate priority so one busy port cannot starve the other.
        // Wait until the last prompt byte has left, so the reply port never changes under a stalled byte.
        if (tx_free && (line_rdy[rr_q] || line_rdy[!rr_q])) begin
          sel_d = line_rdy[rr_q] ? rr_q : !rr_q;
          rr_d = !sel_d;
          idx_d = '0;
          {inq_d, intok_d, fresh_d, named_d, param_d} = '0;
          nm_beg_d = '0;
          nm_end_d = '0;
          msg_d = '0;
          state_d = acl_pkg::S_SCAN;
        end
      end
      acl_pkg::S_SCAN: begin
        if (idx_q == line_len[sel_q]) begin
          if (intok_q && !named_q) begin
            nm_end_d = idx_q;
          end
          query_d = !param_q;
          if (line_ovf[sel_q] || inq_q) begin
            status_d = acl_pkg::ST_ERR;
            code_d = line_ovf[sel_q] ? acl_pkg::ERR_OVERFLOW : acl_pkg::ERR_QUOTE;
            state_d = acl_pkg::S_MSG;
          end else if (!intok_q && !named_q) begin
            // Empty line: nothing to run, just a fresh prompt.
            state_d = acl_pkg::S_CR;
          end else begin
            cmd_end_d = 1'b1;
            state_d = acl_pkg::S_WAIT;
          end
        end else begin
          idx_d = idx_q + 1'b1;
          if (cur == acl_pkg::CH_QUOTE) begin
            // Quotes group text, spaces included, into one token.
            inq_d = !inq_q;
            if (!intok_q) begin
              intok_d = 1'b1;
              fresh_d = 1'b1;
              param_d = param_q || named_q;
              if (!named_q) begin
                nm_beg_d = idx_q;
              end
            end
          end else if (cur == acl_pkg::CH_SP && !inq_q) begin
            // Unquoted space ends a token; runs of spaces collapse.
            if (intok_q) begin
              intok_d = 1'b0;
              if (!named_q) begin
                named_d = 1'b1;
                nm_end_d = idx_q;
              end
            end
          end else begin
            tok_valid_d = 1'b1;
            tok_data_d = cur;
            tok_first_d = !intok_q || fresh_q;
            tok_name_d = !named_q;
            intok_d = 1'b1;
            fresh_d = 1'b0;
            if (!intok_q) begin
              param_d = param_q || named_q;
              if (!named_q) begin
                nm_beg_d = idx_q;
              end
            end
          end
        end
      end
      acl_pkg::S_WAIT: begin
        if (I_EXEC_DONE) begin
          status_d = I_EXEC_STATUS;
          code_d = I_EXEC_CODE;
          if (I_EXEC_STATUS != acl_pkg::ST_ERR && query_q) begin
            idx_d = nm_beg_q;
            state_d = acl_pkg::S_NAME;
          end else if (I_EXEC_STATUS != acl_pkg::ST_OK) begin
            state_d = acl_pkg::S_MSG;
          end else begin
            state_d = acl_pkg::S_CR;
          end
        end
      end
      acl_pkg::S_NAME: begin
        // Replay the name as received, then a space before the values.
        if (tx_free) begin
          tx_valid_d = 1'b1;
          if (idx_q == nm_end_q) begin
            tx_data_d = acl_pkg::CH_SP;
            state_d = acl_pkg::S_VALS;
          end else begin
            tx_data_d = cur;
            idx_d = idx_q + 1'b1;
          end
        end
      end
      acl_pkg::S_VALS: begin
        // Values come formatted by the executor, optional ones only if needed.
        if (tx_free && I_VAL_VALID) begin
          tx_valid_d = 1'b1;
          tx_data_d = I_VAL_DATA;
          if (I_VAL_LAST) begin
            state_d = (status_q == acl_pkg::ST_WARN) ? acl_pkg::S_MSGSP : acl_pkg::S_CR;
          end
        end
      end
      acl_pkg::S_MSGSP: begin
        if (tx_free) begin
          tx_valid_d = 1'b1;
          tx_data_d = acl_pkg::CH_SP;
          state_d = acl_pkg::S_MSG;
        end
      end
      acl_pkg::S_MSG: begin
        // Letter then three digits; a warning only follows a completed command.
        if (tx_free) begin
          tx_valid_d = 1'b1;
          if (msg_q == '0) begin
            tx_data_d = (status_q == acl_pkg::ST_ERR) ? acl_pkg::CH_ERR : acl_pkg::CH_WARN;
          end else begin
            tx_data_d = acl_pkg::CH_ZERO + {4'h0, digit};
          end
          msg_d = msg_q + 1'b1;
          if (msg_q == acl_pkg::MSG_LAST) begin
            state_d = acl_pkg::S_CR;
          end
        end
      end
      acl_pkg::S_CR: begin
        // Every command, good or bad, closes with CR LF and a prompt.
        if (tx_free) begin
          tx_valid_d = 1'b1;
          tx_data_d = acl_pkg::CH_CR;
          state_d = acl_pkg::S_LF;
        end
      end
      acl_pkg::S_LF: begin
        if (tx_free) begin
          tx_valid_d = 1'b1;
          tx_data_d = acl_pkg::CH_LF;
          state_d = acl_pkg::S_PROMPT;
        end
      end
      acl_pkg::S_PROMPT: begin
        if (tx_free) begin
          tx_valid_d = 1'b1;
          tx_data_d = acl_pkg::CH_PROMPT;
          state_d = acl_pkg::S_IDLE;
        end
      end
      default: begin
        state_d = acl_pkg::S_IDLE;
      end
    endcase
  end

  // Register the sequencer, token and reply state.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_q <= acl_pkg::S_IDLE;
      sel_q <= acl_pkg::PORT_SER;
      rr_q <= acl_pkg::PORT_SER;
      idx_q <= '0;
      {inq_q, intok_q, fresh_q, named_q, param_q} <= '0;
      nm_beg_q <= '0;
      nm_end_q <= '0;
      status_q <= acl_pkg::ST_OK;
      code_q <= '0;
      msg_q <= '0;
      query_q <= 1'b0;
      tok_valid_q <= 1'b0;
      tok_data_q <= '0;
      tok_first_q <= 1'b0;
      tok_name_q <= 1'b0;
      cmd_end_q <= 1'b0;
      tx_valid_q <= 1'b0;
      tx_data_q <= '0;
    end else begin
      state_q <= state_d;
      sel_q <= sel_d;
      rr_q <= rr_d;
      idx_q <= idx_d;
      {inq_q, intok_q, fresh_q, named_q, param_q} <= {inq_d, intok_d, fresh_d, named_d, param_d};
      nm_beg_q <= nm_beg_d;
      nm_end_q <= nm_end_d;
      status_q <= status_d;
      code_q <= code_d;
      msg_q <= msg_d;
      query_q <= query_d;
      tok_valid_q <= tok_valid_d;
      tok_data_q <= tok_data_d;
      tok_first_q <= tok_first_d;
      tok_name_q <= tok_name_d;
      cmd_end_q <= cmd_end_d;
      tx_valid_q <= tx_valid_d;
      tx_data_q <= tx_data_d;
    end
  end

  assign O_TOK_VALID = tok_valid_q;
  assign O_TOK_DATA = tok_data_q;
  assign O_TOK_FIRST = tok_first_q;
  assign O_TOK_NAME = tok_name_q;
  assign O_CMD_END = cmd_end_q;
  assign O_CMD_QUERY = query_q;
  assign O_CMD_PORT = sel_q;
  assign O_TX_VALID = tx_valid_q;
  assign O_TX_DATA = tx_data_q;
  assign O_TX_PORT = sel_q;
endmodule
`default_nettype wire

/* tb/acl_checker.sv */
// Concurrent checks on the ports of the ASCII command line parser.
`default_nettype none
module acl_checker (
  // Clock, reset and receive streams.
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic I_SER_VALID, I_TCP_VALID, O_SER_READY, O_TCP_READY,
  input wire logic [7:0] I_SER_DATA, I_TCP_DATA,
  input wire logic [15:0] O_TCP_PORT_NUM,
  // Tokens and executor outcome.
  input wire logic O_TOK_VALID, O_CMD_END, O_CMD_QUERY, I_EXEC_DONE,
  input wire logic [7:0] O_TOK_DATA,
  input wire logic [1:0] I_EXEC_STATUS,
  // Reply stream.
  input wire logic O_TX_VALID, O_TX_PORT, I_TX_READY,
  input wire logic [7:0] O_TX_DATA
);
  // High between a finished line and the executor's answer, since DONE only counts then.
  logic wait_q;
  logic wait_d;
  // Next value of the waiting flag.
  always_comb begin
    wait_d = wait_q;
    if (O_CMD_END) begin
      wait_d = 1'b1;
    end else if (I_EXEC_DONE) begin
      wait_d = 1'b0;
    end
  end
  // Register the waiting flag.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= wait_d;
    end
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  property p_port_num; O_TCP_PORT_NUM == 16'h0017; endproperty
  a_port_num: assert property (p_port_num) else $error("tcp port number wrong");
  property p_ser_lf; I_SER_VALID && O_SER_READY && I_SER_DATA == 8'h0A |=> !O_SER_READY; endproperty
  a_ser_lf: assert property (p_ser_lf) else $error("serial ready stayed high after LF");
  property p_tcp_lf; I_TCP_VALID && O_TCP_READY && I_TCP_DATA == 8'h0A |=> !O_TCP_READY; endproperty
  a_tcp_lf: assert property (p_tcp_lf) else $error("tcp ready stayed high after LF");
  property p_end_held; O_CMD_END |-> !O_SER_READY || !O_TCP_READY; endproperty
  a_end_held: assert property (p_end_held) else $error("line parsed while no port held");
  property p_tok_lf; O_TOK_VALID |-> O_TOK_DATA != 8'h0A; endproperty
  a_tok_lf: assert property (p_tok_lf) else $error("line feed passed on as token");
  property p_tok_quote; O_TOK_VALID |-> O_TOK_DATA != 8'h22; endproperty
  a_tok_quote: assert property (p_tok_quote) else $error("quote passed on as token");
  // The outcome is taken on one edge and the message letter is loaded on the next, so it shows two edges on.
  property p_err;
    wait_q && I_EXEC_DONE && I_EXEC_STATUS == 2'h2 && !O_TX_VALID |-> ##2 O_TX_VALID && O_TX_DATA == 8'h45;
  endproperty
  a_err: assert property (p_err) else $error("error reply does not start with E");
  property p_warn;
    wait_q && I_EXEC_DONE && I_EXEC_STATUS == 2'h1 && !O_CMD_QUERY && !O_TX_VALID
      |-> ##2 O_TX_VALID && O_TX_DATA == 8'h57;
  endproperty
  a_warn: assert property (p_warn) else $error("warning reply does not start with W");
  property p_hold; O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_DATA) && $stable(O_TX_PORT); endproperty
  a_hold: assert property (p_hold) else $error("reply byte changed while stalled");
  property p_prompt; O_TX_VALID && I_TX_READY && O_TX_DATA == 8'h0A |=> O_TX_VALID && O_TX_DATA == 8'h3E; endproperty
  a_prompt: assert property (p_prompt) else $error("line break not followed by prompt");
endmodule
bind acl_parser acl_checker u_chk (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_SER_VALID(I_SER_VALID),
  .I_TCP_VALID(I_TCP_VALID), .O_SER_READY(O_SER_READY), .O_TCP_READY(O_TCP_READY), .I_SER_DATA(I_SER_DATA),
  .I_TCP_DATA(I_TCP_DATA), .O_TCP_PORT_NUM(O_TCP_PORT_NUM), .O_TOK_VALID(O_TOK_VALID), .O_CMD_END(O_CMD_END),
  .O_CMD_QUERY(O_CMD_QUERY), .I_EXEC_DONE(I_EXEC_DONE), .O_TOK_DATA(O_TOK_DATA), .I_EXEC_STATUS(I_EXEC_STATUS),
  .O_TX_VALID(O_TX_VALID), .O_TX_PORT(O_TX_PORT), .I_TX_READY(I_TX_READY), .O_TX_DATA(O_TX_DATA));
`default_nettype wire

/* tb/acl_host.sv */
// Host model that sends command lines on either port and sinks the reply stream.
`default_nettype none
module acl_host (
  // Clock and pacing.
  input wire logic i_clk,
  input wire logic i_slow,
  // Byte streams towards the parser.
  output logic o_ser_valid,
  output logic [7:0] o_ser_data,
  input wire logic i_ser_ready,
  output logic o_tcp_valid,
  output logic [7:0] o_tcp_data,
  input wire logic i_tcp_ready,
  // Reply sink.
  output logic o_tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle streams at time zero.
  initial begin
    o_ser_valid = 1'b0;
    o_ser_data = 8'h00;
    o_tcp_valid = 1'b0;
    o_tcp_data = 8'h00;
    o_tx_ready = 1'b1;
  end
  // A slow host takes a reply byte only every other cycle, to stress the hold.
  always @(negedge i_clk) begin
    o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
  end
  // Each byte stands until the parser takes it; the caller ends lines with LF.
  task automatic send(input logic port, input string s, output bit ok);
    int n;
    ok = 1'b1;
    for (int i = 0; i < s.len(); i++) begin
      @(negedge i_clk);
      if (port) begin
        o_tcp_valid = 1'b1;
        o_tcp_data = s[i];
      end else begin
        o_ser_valid = 1'b1;
        o_ser_data = s[i];
      end
      // Ready only moves on a rising edge, so it is settled here; the byte goes at the next edge.
      n = 0;
      while ((port ? i_tcp_ready : i_ser_ready) !== 1'b1 && n < 200) begin
        @(negedge i_clk);
        n++;
      end
      if (n >= 200) ok = 1'b0;
      @(posedge i_clk);
    end
    @(negedge i_clk);
    // Released lines show the inverse, so a stale byte is never mistaken for data.
    o_ser_valid = 1'b0;
    o_tcp_valid = 1'b0;
    o_ser_data = ~o_ser_data;
    o_tcp_data = ~o_tcp_data;
  endtask
endmodule
`default_nettype wire

/* tb/acl_parser_tb.sv */
// Self-checking bench for the ASCII command line parser.
`default_nettype none
module acl_parser_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Design connections and bench state.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sv, tv, sr, tr, tok_v, tok_f, cend, cq, cport, done, val_v, val_last, val_r, tx_v, tx_p, tx_r, slow;
  logic [7:0] sd, td, tok_d, val_d, tx_d;
  logic [15:0] pnum;
  logic [1:0] st;
  logic [11:0] code;
  logic q_cap, p_cap, tok_n;
  int errors = 0;
  int comparisons = 0;
  int ends = 0;
  string tok_s, tx_s;
  always #12.5 clk = ~clk;
  acl_parser #(.DEPTH(64)) dut (
    .I_CLK(clk), .I_RESET_N(rst_n), .I_SER_VALID(sv), .I_SER_DATA(sd), .O_SER_READY(sr),
    .I_TCP_VALID(tv), .I_TCP_DATA(td), .O_TCP_READY(tr), .O_TCP_PORT_NUM(pnum),
    .O_TOK_VALID(tok_v), .O_TOK_DATA(tok_d), .O_TOK_FIRST(tok_f), .O_TOK_NAME(tok_n), .O_CMD_END(cend),
    .O_CMD_QUERY(cq), .O_CMD_PORT(cport), .I_EXEC_DONE(done), .I_EXEC_STATUS(st), .I_EXEC_CODE(code),
    .I_VAL_VALID(val_v), .I_VAL_DATA(val_d), .I_VAL_LAST(val_last), .O_VAL_READY(val_r),
    .O_TX_VALID(tx_v), .O_TX_DATA(tx_d), .O_TX_PORT(tx_p), .I_TX_READY(tx_r));
  acl_host host (.i_clk(clk), .i_slow(slow), .o_ser_valid(sv), .o_ser_data(sd), .i_ser_ready(sr),
    .o_tcp_valid(tv), .o_tcp_data(td), .i_tcp_ready(tr), .o_tx_ready(tx_r));
  // Compare a value; an unknown bit matches only an unknown bit.
  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Compare collected text.
  task automatic chk_s(input string got, input string exp, input string what);
    comparisons++;
    if (got != exp) begin
      errors++;
      $display("mismatch at %0t: %s got <%s> expected <%s>", $time, what, got, exp);
    end
  endtask
  // Print the verdict and stop.
  task automatic conclude();
    if (errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // A wait that ran out counts as a mismatch and ends the run.
  task automatic give_up(input string what);
    chk_v(16'h0000, 16'h0001, what);
    conclude();
  endtask
  // Collect tokens (a hash marks the name's first byte, a bar a parameter's) and accepted reply bytes.
  // Sampled just after the falling edge, where outputs and the sink's ready are settled for the next edge.
  always @(negedge clk) begin
    #1;
    if (tok_v === 1'b1 && tok_f === 1'b1 && tok_n === 1'b1) tok_s = {tok_s, "#"};
    if (tok_v === 1'b1 && tok_f === 1'b1 && tok_n !== 1'b1) tok_s = {tok_s, "|"};
    if (tok_v === 1'b1) tok_s = $sformatf("%s%c", tok_s, tok_d);
    if (cend === 1'b1) begin
      ends++;
      q_cap = cq;
      p_cap = cport;
    end
    if (tx_v === 1'b1 && tx_r === 1'b1) begin
      tx_s = $sformatf("%s%c", tx_s, tx_d);
      chk_v(tx_p, p_cap, "reply port");
    end
  end
  // Send a line, act as executor with the given outcome, then judge tokens and reply.
  task automatic run(input logic port, input string line, input logic [1:0] sts, input logic [11:0] cd,
                     input string etok, input logic eq, input string etx);
    bit ok;
    int n;
    tok_s = "";
    tx_s = "";
    ends = 0;
    host.send(port, line, ok);
    n = 0;
    while (ends == 0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (!ok || ends == 0) give_up("line not parsed");
    chk_s(tok_s, etok, "tokens");
    chk_v(q_cap, eq, "query flag");
    chk_v(p_cap, port, "command port");
    st = sts;
    code = cd;
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    if (eq && sts != 2'h2) begin
      val_v = 1'b1;
      val_d = 8'h37;
      val_last = 1'b1;
      // Value ready is judged where it is settled; the byte then goes at the next rising edge.
      n = 0;
      #1;
      while (val_r !== 1'b1 && n < 100) begin
        @(negedge clk);
        #1;
        n++;
      end
      if (n >= 100) give_up("value not taken");
      @(negedge clk);
      val_v = 1'b0;
      val_d = 8'hC8;
    end
    n = 0;
    while (tx_s.len() < etx.len() && n < 300) begin
      @(negedge clk);
      n++;
    end
    repeat (4) @(negedge clk);
    chk_s(tx_s, etx, "reply");
    chk_v(port ? tr : sr, 1'b1, "ready after prompt");
  endtask
  // Send a line that the parser answers by itself: no command may be raised, only the reply.
  task automatic run_local(input logic port, input string line, input string etx);
    bit ok;
    int n;
    tx_s = "";
    ends = 0;
    p_cap = port;
    host.send(port, line, ok);
    if (!ok) give_up("line not taken");
    n = 0;
    while (tx_s.len() < etx.len() && n < 300) begin
      @(negedge clk);
      n++;
    end
    repeat (4) @(negedge clk);
    chk_s(tx_s, etx, "local reply");
    chk_v(ends[15:0], 16'h0000, "local line command");
  endtask
  // Serial query: reply is the name and its value, resendable as is.
  task automatic t_query();
    run(1'b0, "AB\n", 2'h0, 12'h000, "#AB", 1'b1, "AB 7\015\n>");
  endtask
  // TCP line with a quoted parameter and CR LF ending fails, with a stalling sink.
  task automatic t_error();
    slow = 1'b1;
    run(1'b1, "K \"x y\"\015\n", 2'h2, 12'h123, "#K|x y", 1'b0, "E123\015\n>");
    slow = 1'b0;
  endtask
  // Setting with a warning still ends in line break and prompt.
  task automatic t_warn();
    run(1'b0, "S 1\n", 2'h1, 12'h045, "#S|1", 1'b0, "W045\015\n>");
  endtask
  // Query on TCP that draws a warning after its values.
  task automatic t_query_warn();
    run(1'b1, "AB\n", 2'h1, 12'h045, "#AB", 1'b1, "AB 7 W045\015\n>");
  endtask
  // An open quote and a line longer than the 64-byte buffer are refused by the parser itself.
  task automatic t_local_err();
    string s;
    s = "";
    for (int i = 0; i < 70; i++) begin
      s = {s, "A"};
    end
    run_local(1'b0, "Q \"ab\n", "E902\015\n>");
    run_local(1'b1, {s, "\n"}, "E901\015\n>");
  endtask
  // A blank line raises no command but is still answered with a prompt.
  task automatic t_blank();
    run_local(1'b1, " \n", "\015\n>");
  endtask
  // Main sequence: reset for five cycles, then the scenarios.
  initial begin
    done = 1'b0;
    st = 2'h0;
    code = 12'h000;
    val_v = 1'b0;
    val_d = 8'h00;
    val_last = 1'b0;
    slow = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    chk_v(pnum, 16'h0017, "tcp port number");
    t_query();
    t_error();
    t_warn();
    t_query_warn();
    t_local_err();
    t_blank();
    conclude();
  end
endmodule
`default_nettype wire
